// File: hdl/telegram_pkg.sv
// Constants, codes and size lookups shared by the telegram block.
// Assumes a single clock domain and APB register access.
package telegram_pkg;
  localparam int ADDR_W = 12;
  localparam int IDX_W  = 5;
  localparam int PCH_WORDS = 4;
  // Telegram selection codes
  localparam logic [15:0] CODE_FREE  = 16'h03e7;
  localparam logic [15:0] CODE_STD1  = 16'h0001;
  localparam logic [15:0] CODE_STD20 = 16'h0014;
  localparam logic [15:0] CODE_T350  = 16'h015e;
  localparam logic [15:0] CODE_T352  = 16'h0160;
  localparam logic [15:0] CODE_T353  = 16'h0161;
  localparam logic [15:0] CODE_T354  = 16'h0162;
  localparam logic [15:0] RST_TSEL   = CODE_STD1;
  localparam logic [15:0] RST_EXT    = CODE_STD1;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_TSEL     = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_EXT      = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_REQ_ID   = 12'h00c;
  localparam logic [ADDR_W-1:0] ADDR_REQ_VAL  = 12'h010;
  localparam logic [ADDR_W-1:0] ADDR_RSP_CTRL = 12'h014;
  localparam logic [ADDR_W-1:0] ADDR_RSP_VAL  = 12'h018;
  localparam logic [ADDR_W-1:0] ADDR_SRC_BASE = 12'h040;
  localparam logic [ADDR_W-1:0] ADDR_RXW_BASE = 12'h100;
  // Status bit positions
  localparam int ST_PENDING = 0;
  localparam int ST_FREE    = 1;
  localparam int ST_EXTFREE = 2;
  localparam int ST_PCH     = 3;
  localparam int ST_REFUSED = 4;
  localparam int ST_NRX_LSB = 8;
  localparam int ST_NTX_LSB = 16;
  // Parameter channel field positions
  localparam int JOB_MSB  = 15;
  localparam int JOB_LSB  = 12;
  localparam int RSVD_BIT = 11;
  localparam int NUM_MSB  = 10;
  localparam int SUB_LSB  = 8;
  // Job and response codes
  localparam logic [3:0] JOB_NONE    = 4'h0;
  localparam logic [3:0] JOB_DWORD   = 4'h3;
  localparam logic [3:0] JOB_RSVD    = 4'h5;
  localparam logic [3:0] JOB_FDWORD  = 4'h8;
  localparam logic [3:0] JOB_LAST    = 4'h9;
  localparam logic [3:0] RSP_DWORD   = 4'h2;
  localparam logic [3:0] RSP_FDWORD  = 4'h5;
  localparam logic [3:0] RSP_ERROR   = 4'h7;
  localparam logic [15:0] ERR_UNSUPPORTED = 16'h006a;

  typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;

  function automatic logic code_known(input logic [15:0] c);
    return c == CODE_STD1 || c == CODE_STD20 || c == CODE_T350 ||
           c == CODE_T352 || c == CODE_T353 || c == CODE_T354;
  endfunction

  function automatic logic [IDX_W-1:0] code_rx(input logic [15:0] c);
    case (c)
      CODE_STD1, CODE_STD20, CODE_T353: return 5'h02;
      CODE_T350:                        return 5'h04;
      CODE_T352, CODE_T354:             return 5'h06;
      default:                          return 5'h00;
    endcase
  endfunction

  function automatic logic [IDX_W-1:0] code_tx(input logic [15:0] c);
    case (c)
      CODE_STD1, CODE_T353:             return 5'h02;
      CODE_T350:                        return 5'h04;
      CODE_STD20, CODE_T352, CODE_T354: return 5'h06;
      default:                          return 5'h00;
    endcase
  endfunction

  function automatic logic code_pch(input logic [15:0] c);
    return c == CODE_T353 || c == CODE_T354;
  endfunction
endpackage

// File: hdl/send_word_select.sv
// Picks one word-format actual value out of the flat source bus.
// Assumes the select is stable for the cycle it is used.
module send_word_select #(
  parameter int NSRC  = 16,
  parameter int SEL_W = 4
) (
  input  wire logic [NSRC*16-1:0] sources,
  input  wire logic [SEL_W-1:0]   sel,
  output logic      [15:0]        word
);
  always_comb
  begin
    word = 16'h0000;
    // Out-of-range selects read zero rather than wrapping
    if (int'(sel) < NSRC)
    begin
      word = sources[int'(sel)*16 +: 16];
    end
  end
endmodule // send_word_select

// File: hdl/param_word_codec.sv
// Splits a parameter-channel request into fields and packs a response.
// Purely combinational; the caller registers what it needs.
module param_word_codec
  import telegram_pkg::*;
(
  input  wire logic [15:0] req_id,
  input  wire logic [15:0] req_index,
  input  wire logic [15:0] req_val_hi,
  input  wire logic [15:0] req_val_lo,
  input  wire logic [3:0]  rsp_code,
  input  wire logic [31:0] rsp_value,
  output logic      [3:0]  job,
  output logic             reject,
  output logic      [31:0] value32,
  output logic      [15:0] rsp_w0,
  output logic      [15:0] rsp_w1,
  output logic      [15:0] rsp_w2,
  output logic      [15:0] rsp_w3
);
  logic dbl_req;
  logic wide_rsp;

  assign job = req_id[JOB_MSB:JOB_LSB];
  assign dbl_req = job == JOB_DWORD || job == JOB_FDWORD;
  // A set reserved bit or an unknown job cannot be served
  assign reject = job != JOB_NONE &&
                  (req_id[RSVD_BIT] || job == JOB_RSVD || job > JOB_LAST);
  // Upper half travels in the first value word
  assign value32 = dbl_req ? {req_val_hi, req_val_lo}
                           : {16'h0000, req_val_lo};

  assign wide_rsp = rsp_code == RSP_DWORD || rsp_code == RSP_FDWORD ||
                    rsp_code == RSP_ERROR;
  // Echo number and index; reserved bit always sent as zero
  assign rsp_w0 = {rsp_code, 1'b0, req_id[NUM_MSB:0]};
  assign rsp_w1 = {req_index[15:SUB_LSB], req_index[SUB_LSB-1:0]};
  assign rsp_w2 = wide_rsp ? rsp_value[31:16] : 16'h0000;
  assign rsp_w3 = rsp_value[15:0];
endmodule // param_word_codec

// File: hdl/telegram_channel.sv
// Cyclic telegram mapping and parameter-channel framing, APB slave.
// Assumes link words arrive on MCLK and the master waits for the reply.
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
module telegram_channel
  import telegram_pkg::*;
#(
  parameter int MAX_RX = 12,
  parameter int MAX_TX = 17,
  parameter int NSRC   = 16
) (
  input  wire logic                            MCLK,
  input  wire logic                            SRST,
  input  wire logic                            PSEL,
  input  wire logic                            PENABLE,
  input  wire logic                            PWRITE,
  input  wire logic [telegram_pkg::ADDR_W-1:0] PADDR,
  input  wire logic [31:0]                     PWDATA,
  output logic      [31:0]                     PRDATA,
  output logic                                 PREADY,
  output logic                                 PSLVERR,
  input  wire logic                            LINK_RX_VALID,
  input  wire logic [15:0]                     LINK_RX_DATA,
  input  wire logic                            LINK_RX_LAST,
  output logic                                 LINK_TX_VALID,
  output logic      [15:0]                     LINK_TX_DATA,
  output logic                                 LINK_TX_LAST,
  input  wire logic [NSRC*16-1:0]              ACT_VALUES,
  output logic      [MAX_RX*16-1:0]            RX_WORDS
);
  import telegram_pkg::*;

  localparam int SEL_W = $clog2(NSRC);

  typedef struct packed {
    logic [15:0]                   tsel;
    logic [15:0]                   ext;
    logic [MAX_TX-1:0][SEL_W-1:0]  src;
    logic [MAX_RX-1:0][15:0]       rxw;
    logic [PCH_WORDS-1:0][15:0]    req;
    logic [PCH_WORDS-1:0][15:0]    seen;
    logic [3:0]                    rsp_code;
    logic [31:0]                   rsp_value;
    logic                          pending;
    logic                          refused;
    logic                          frame_end;
    logic [IDX_W-1:0]              rx_idx;
    logic [IDX_W-1:0]              tx_idx;
    tx_state_t                     st;
    logic                          tx_valid;
    logic                          tx_last;
    logic [15:0]                   tx_data;
    logic                          pready;
    logic                          pslverr;
    logic [31:0]                   prdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic              free;
  logic              ext_free;
  logic              pch_en;
  logic [IDX_W-1:0]  nrx;
  logic [IDX_W-1:0]  ntx;
  logic [IDX_W-1:0]  base_tx;
  logic [IDX_W-1:0]  pch_off;
  logic [IDX_W-1:0]  total_tx;
  logic [MAX_TX-1:0] locked;
  logic [ADDR_W-1:0] src_off;
  logic [ADDR_W-1:0] rxw_off;
  logic [IDX_W-1:0]  src_i;
  logic [IDX_W-1:0]  rxw_i;
  logic              src_hit;
  logic              rxw_hit;
  logic              wr_refuse;
  logic [31:0]       rd_data;
  logic [IDX_W-1:0]  tx_k;
  logic [SEL_W-1:0]  mux_sel;
  logic [15:0]       act_word;
  logic [3:0]        job;
  logic              reject;
  logic [31:0]       value32;
  logic [15:0]       rsp_w [PCH_WORDS];

  // Effective telegram geometry
  assign free     = s_q.tsel == CODE_FREE;
  assign ext_free = free && s_q.ext == CODE_FREE;
  assign base_tx  = code_tx(s_q.ext);
  assign nrx = !free ? code_rx(s_q.tsel) : IDX_W'(MAX_RX);
  assign ntx = !free ? code_tx(s_q.tsel) : IDX_W'(MAX_TX);
  assign pch_en = !free ? code_pch(s_q.tsel)
                        : (!ext_free && code_pch(s_q.ext));
  assign pch_off  = pch_en ? IDX_W'(PCH_WORDS) : '0;
  assign total_tx = ntx + pch_off;

  always_comb
  begin
    for (int i = 0; i < MAX_TX; i++)
    begin
      locked[i] = !free || (!ext_free && IDX_W'(i) < base_tx);
    end
  end

  assign src_off = PADDR - ADDR_SRC_BASE;
  assign rxw_off = PADDR - ADDR_RXW_BASE;
  assign src_i   = src_off[IDX_W+1:2];
  assign rxw_i   = rxw_off[IDX_W+1:2];
  assign src_hit = PADDR >= ADDR_SRC_BASE && PADDR[1:0] == 2'b00 &&
                   src_off < ADDR_W'(MAX_TX * 4);
  assign rxw_hit = PADDR >= ADDR_RXW_BASE && PADDR[1:0] == 2'b00 &&
                   rxw_off < ADDR_W'(MAX_RX * 4);

  // Decided from the address and data held stable through the access
  always_comb
  begin
    wr_refuse = 1'b0;
    case (PADDR)
      ADDR_TSEL:
        wr_refuse = !code_known(PWDATA[15:0]) && PWDATA[15:0] != CODE_FREE;
      ADDR_EXT:
        wr_refuse = !free || (!code_known(PWDATA[15:0]) &&
                    PWDATA[15:0] != CODE_FREE);
      ADDR_STATUS, ADDR_RSP_CTRL, ADDR_RSP_VAL:
        wr_refuse = 1'b0;
      default:
        wr_refuse = !src_hit || locked[src_i] ||
                    PWDATA >= 32'(NSRC);
    endcase
  end

  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (PADDR)
      ADDR_TSEL:     rd_data = {16'h0000, s_q.tsel};
      ADDR_EXT:      rd_data = {16'h0000, s_q.ext};
      ADDR_STATUS:
      begin
        rd_data[ST_PENDING] = s_q.pending;
        rd_data[ST_FREE]    = free;
        rd_data[ST_EXTFREE] = ext_free;
        rd_data[ST_PCH]     = pch_en;
        rd_data[ST_REFUSED] = s_q.refused;
        rd_data[ST_NRX_LSB +: IDX_W] = nrx;
        rd_data[ST_NTX_LSB +: IDX_W] = ntx;
      end
      ADDR_REQ_ID:   rd_data = {s_q.req[0], s_q.req[1]};
      ADDR_REQ_VAL:  rd_data = value32;
      ADDR_RSP_CTRL: rd_data = {28'h0000000, s_q.rsp_code};
      ADDR_RSP_VAL:  rd_data = s_q.rsp_value;
      default:
      begin
        if (src_hit)
        begin
          rd_data = 32'(s_q.src[src_i]);
        end
        else if (rxw_hit)
        begin
          rd_data = {16'h0000, s_q.rxw[rxw_i]};
        end
      end
    endcase
  end

  param_word_codec u_codec (
    .req_id     (s_q.req[0]),
    .req_index  (s_q.req[1]),
    .req_val_hi (s_q.req[2]),
    .req_val_lo (s_q.req[3]),
    .rsp_code   (s_q.rsp_code),
    .rsp_value  (s_q.rsp_value),
    .job        (job),
    .reject     (reject),
    .value32    (value32),
    .rsp_w0     (rsp_w[0]),
    .rsp_w1     (rsp_w[1]),
    .rsp_w2     (rsp_w[2]),
    .rsp_w3     (rsp_w[3])
  );

  assign tx_k    = s_q.tx_idx - pch_off;
  assign mux_sel = (tx_k < IDX_W'(MAX_TX)) ? s_q.src[tx_k] : '0;

  send_word_select #(
    .NSRC  (NSRC),
    .SEL_W (SEL_W)
  ) u_select (
    .sources (ACT_VALUES),
    .sel     (mux_sel),
    .word    (act_word)
  );

  always_comb
  begin
    logic [IDX_W-1:0] k;
    k = '0;
    s_d = s_q;
    // APB: one wait state, write and read data settle at the PREADY edge
    s_d.pready  = PSEL && PENABLE && !s_q.pready;
    s_d.pslverr = 1'b0;
    s_d.prdata  = 32'h0000_0000;
    if (PSEL && PENABLE && !s_q.pready)
    begin
      s_d.pslverr = PWRITE && wr_refuse;
      s_d.prdata  = PWRITE ? 32'h0000_0000 : rd_data;
    end
    if (PSEL && PENABLE && s_q.pready && PWRITE)
    begin
      if (wr_refuse)
      begin
        s_d.refused = 1'b1;
      end
      else
      begin
        case (PADDR)
          ADDR_TSEL:     s_d.tsel = PWDATA[15:0];
          ADDR_EXT:      s_d.ext = PWDATA[15:0];
          ADDR_STATUS:
            s_d.refused = s_q.refused && !PWDATA[ST_REFUSED];
          ADDR_RSP_CTRL:
          begin
            s_d.rsp_code = PWDATA[3:0];
            s_d.pending  = 1'b0;
          end
          ADDR_RSP_VAL:  s_d.rsp_value = PWDATA;
          default:       s_d.src[src_i] = PWDATA[SEL_W-1:0];
        endcase
      end
    end
    // Protected positions fall back to their default source
    for (int i = 0; i < MAX_TX; i++)
    begin
      if (locked[i])
      begin
        s_d.src[i] = SEL_W'(i);
      end
    end

    // Receive side: parameter words first, then cyclic words
    s_d.frame_end = 1'b0;
    if (LINK_RX_VALID)
    begin
      if (pch_en && s_q.rx_idx < IDX_W'(PCH_WORDS))
      begin
        s_d.req[s_q.rx_idx[1:0]] = LINK_RX_DATA;
      end
      else
      begin
        k = s_q.rx_idx - pch_off;
        if (k < nrx)
        begin
          s_d.rxw[k] = LINK_RX_DATA;
        end
      end
      if (s_q.rx_idx != '1)
      begin
        s_d.rx_idx = s_q.rx_idx + 1'b1;
      end
      if (LINK_RX_LAST)
      begin
        s_d.rx_idx    = '0;
        s_d.frame_end = 1'b1;
      end
    end

    // One cycle after the frame the request words are complete
    if (s_q.frame_end)
    begin
      if (pch_en)
      begin
        s_d.seen = s_q.req;
        if (job == JOB_NONE)
        begin
          s_d.rsp_code = JOB_NONE;
          s_d.pending  = 1'b0;
        end
        else if (reject)
        begin
          s_d.rsp_code  = RSP_ERROR;
          s_d.rsp_value = {ERR_UNSUPPORTED, 16'h0000};
          s_d.pending   = 1'b0;
        end
        else if (s_q.req != s_q.seen)
        begin
          // Software answers via the response registers
          s_d.rsp_code = JOB_NONE;
          s_d.pending  = 1'b1;
        end
      end
      if (total_tx != '0 && s_q.st == TX_IDLE)
      begin
        s_d.st     = TX_SEND;
        s_d.tx_idx = '0;
      end
    end

    // Reply frame: parameter words, then the mapped actual values
    case (s_q.st)
      TX_IDLE:
      begin
        s_d.tx_valid = 1'b0;
        s_d.tx_last  = 1'b0;
        s_d.tx_data  = 16'h0000;
      end
      TX_SEND:
      begin
        s_d.tx_valid = 1'b1;
        s_d.tx_data  = (pch_en && s_q.tx_idx < IDX_W'(PCH_WORDS)) ?
                       rsp_w[s_q.tx_idx[1:0]] : act_word;
        s_d.tx_last  = s_q.tx_idx == total_tx - 1'b1;
        s_d.tx_idx   = s_q.tx_idx + 1'b1;
        if (s_q.tx_idx == total_tx - 1'b1)
        begin
          s_d.st = TX_IDLE;
        end
      end
      default:
      begin
        s_d.st = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      s_q      <= '0;
      s_q.tsel <= RST_TSEL;
      s_q.ext  <= RST_EXT;
      s_q.st   <= TX_IDLE;
      for (int i = 0; i < MAX_TX; i++)
      begin
        s_q.src[i] <= SEL_W'(i);
      end
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign PRDATA        = s_q.prdata;
  assign PREADY        = s_q.pready;
  assign PSLVERR       = s_q.pslverr;
  assign LINK_TX_VALID = s_q.tx_valid;
  assign LINK_TX_DATA  = s_q.tx_data;
  assign LINK_TX_LAST  = s_q.tx_last;
  assign RX_WORDS      = s_q.rxw;

  lock_src_a: assert property (@(posedge MCLK) disable iff (SRST)
    !free |=> s_q.src[3] == SEL_W'(3))
    else $error("protected send source moved");
  unlock_wr_a: assert property (@(posedge MCLK) disable iff (SRST)
    PSEL && PENABLE && s_q.pready && PWRITE && PADDR == ADDR_SRC_BASE &&
    s_q.tsel != CODE_FREE |-> PSLVERR)
    else $error("source write not refused outside free mode");
  ext_guard_a: assert property (@(posedge MCLK) disable iff (SRST)
    PSEL && PENABLE && s_q.pready && PWRITE && PADDR == ADDR_EXT &&
    !free |=> $stable(s_q.ext))
    else $error("extended selection changed outside free mode");
  size_code_a: assert property (@(posedge MCLK) disable iff (SRST)
    s_q.tsel == CODE_STD20 |-> nrx == 5'h02 && ntx == 5'h06 && !pch_en)
    else $error("telegram 20 sizing wrong");
  pch_add_a: assert property (@(posedge MCLK) disable iff (SRST)
    s_q.tsel == CODE_T354 |-> pch_en && total_tx == 5'h0a)
    else $error("telegram 354 parameter channel missing");
  all_free_a: assert property (@(posedge MCLK) disable iff (SRST)
    ext_free |-> locked == '0)
    else $error("free mapping still locked");
  rx_word_a: assert property (@(posedge MCLK) disable iff (SRST)
    LINK_RX_VALID && !pch_en && s_q.rx_idx == '0 && nrx != '0
    |=> RX_WORDS[15:0] == $past(LINK_RX_DATA))
    else $error("received word not presented");
  reply_len_a: assert property (@(posedge MCLK) disable iff (SRST)
    s_q.frame_end && pch_en && s_q.st == TX_IDLE |=> ##1 LINK_TX_VALID[*4])
    else $error("parameter words not framed");
  rsvd_zero_a: assert property (@(posedge MCLK) disable iff (SRST)
    s_q.st == TX_SEND && pch_en && s_q.tx_idx == '0
    |=> LINK_TX_VALID && !LINK_TX_DATA[RSVD_BIT])
    else $error("reserved bit sent set");
  err_resp_a: assert property (@(posedge MCLK) disable iff (SRST)
    s_q.frame_end && pch_en && reject |=>
    s_q.rsp_code == RSP_ERROR && s_q.rsp_value[31:16] == ERR_UNSUPPORTED)
    else $error("rejected request not answered with error");

  reply_c: cover property (@(posedge MCLK) disable iff (SRST)
    LINK_TX_LAST);
  reject_c: cover property (@(posedge MCLK) disable iff (SRST)
    s_q.frame_end && pch_en && reject);
  pending_c: cover property (@(posedge MCLK) disable iff (SRST)
    s_q.pending && ext_free);
  refuse_c: cover property (@(posedge MCLK) disable iff (SRST)
    PSLVERR && PREADY);
endmodule // telegram_channel

// File: tb/link_master_model.sv
// Behavioural fieldbus master: sends request frames, collects reply words.
// Assumes the bench calls send just after a rising clock edge.
module link_master_model (
  input  wire logic        clk,
  input  wire logic        tx_valid,
  input  wire logic [15:0] tx_data,
  input  wire logic        tx_last,
  output logic             rx_valid,
  output logic      [15:0] rx_data,
  output logic             rx_last
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] got [$];
  logic        done = 1'b0;
  initial
  begin
    rx_valid = 1'b0;
    rx_data  = 16'hffff;
    rx_last  = 1'b0;
  end
  // Reserved bit held at zero in every id word built by mk
  function automatic logic [15:0] mk(input logic [3:0] j,
                                     input logic [10:0] p);
    return {j, 1'b0, p};
  endfunction
  // Words go out in array order: any request words first, then cyclic words
  task automatic send(input logic [15:0] w [0:7], input int n);
    got.delete();
    done <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data  <= w[i];
      rx_last  <= (i == n - 1);
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_last  <= 1'b0;
    // Released line shows the inverse so stale data cannot pass
    rx_data  <= ~w[n-1];
  endtask
  always @(posedge clk)
    if (tx_valid)
    begin
      got.push_back(tx_data);
      if (tx_last)
        done <= 1'b1;
    end
endmodule // link_master_model

// File: tb/telegram_channel_tb_top.sv
// Self-checking bench for telegram_channel: APB tasks and link frames.
// Assumes link_master_model on the link side, default parameters.
module telegram_channel_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import telegram_pkg::*;
  logic              mclk = 1'b0;
  logic              srst = 1'b1;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [11:0]       paddr = 12'h000;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              txv;
  logic              txl;
  logic              rxv;
  logic              rxl;
  logic [15:0]       txd;
  logic [15:0]       rxd;
  logic [255:0]      act;
  logic [191:0]      rxw;
  logic [31:0]       r;
  logic [15:0]       f [0:7];
  int                bad_count = 0;
  int                compares = 0;
  int                cyc = 0;
  logic [10:0]       pn = 11'h123;
  logic [15:0]       codes [6] = '{CODE_STD1, CODE_STD20, CODE_T350,
                                   CODE_T352, CODE_T353, CODE_T354};
  logic [4:0]        nrx [6] = '{5'd2, 5'd2, 5'd4, 5'd6, 5'd2, 5'd6};
  logic [4:0]        ntx [6] = '{5'd2, 5'd6, 5'd4, 5'd6, 5'd2, 5'd6};
  logic              pk [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};

  telegram_channel dut (.MCLK(mclk), .SRST(srst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .LINK_RX_VALID(rxv), .LINK_RX_DATA(rxd), .LINK_RX_LAST(rxl),
    .LINK_TX_VALID(txv), .LINK_TX_DATA(txd), .LINK_TX_LAST(txl),
    .ACT_VALUES(act), .RX_WORDS(rxw));
  link_master_model m (.clk(mclk), .tx_valid(txv), .tx_data(txd),
    .tx_last(txl), .rx_valid(rxv), .rx_data(rxd), .rx_last(rxl));

  always #5 mclk = ~mclk;
  // Whole run needs a few hundred cycles; this ceiling only cuts hangs
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Idle edge first so release and next setup never share a time step
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic e);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic ee);
    logic e;
    apb(1'b1, a, d, e);
    chk("pslverr", {31'h0, ee}, {31'h0, e});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] mask,
                    input logic [31:0] ex);
    logic e;
    apb(1'b0, a, 32'h0, e);
    chk("prdata", ex, r & mask);
  endtask
  task automatic frame(input int n, input int nr);
    m.send(f, n);
    while (m.done !== 1'b1)
      @(posedge mclk);
    chk("tx count", nr, m.got.size());
  endtask

  initial
  begin
    for (int s = 0; s < 16; s++)
      act[16*s +: 16] = 16'ha000 + 16'(s);
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    rd(ADDR_TSEL, 32'hffffffff, 32'h1);
    rd(ADDR_STATUS, 32'h001f1f0f, 32'h00020200);
    wr(ADDR_SRC_BASE, 32'h5, 1'b1);
    wr(ADDR_EXT, 32'h1, 1'b1);
    wr(ADDR_TSEL, 32'h5, 1'b1);
    wr(12'hff0, 32'h1, 1'b1);
    wr(ADDR_RXW_BASE, 32'h1, 1'b1);
    rd(12'hff0, 32'hffffffff, 32'h0);
    rd(ADDR_STATUS, 32'h10, 32'h10);
    $display("test reset and locks done");
    foreach (codes[i])
    begin
      wr(ADDR_TSEL, {16'h0, codes[i]}, 1'b0);
      rd(ADDR_STATUS, 32'h001f1f08, {11'h0, ntx[i], 3'h0, nrx[i],
         4'h0, pk[i], 3'h0});
    end
    $display("test sizing done");
    wr(ADDR_TSEL, 32'h1, 1'b0);
    f[0] = 16'h1111;
    f[1] = 16'h2222;
    frame(2, 2);
    chk("rx words", 32'h22221111, rxw[31:0]);
    chk("tx word0", 32'ha000, m.got[0]);
    chk("tx word1", 32'ha001, m.got[1]);
    $display("test cyclic done");
    wr(ADDR_TSEL, 32'h161, 1'b0);
    f = '{m.mk(JOB_DWORD, pn), 16'h0502, 16'h1234, 16'h5678,
          16'h3333, 16'h4444, 16'h0, 16'h0};
    frame(6, 6);
    rd(ADDR_REQ_ID, 32'hffffffff, {f[0], f[1]});
    rd(ADDR_REQ_VAL, 32'hffffffff, 32'h12345678);
    rd(ADDR_STATUS, 32'h1, 32'h1);
    chk("rsp id", {5'h0, pn}, m.got[0]);
    chk("rsp index", 32'h0502, m.got[1]);
    chk("rsp hi", 32'h0, m.got[2]);
    chk("rsp cyclic", 32'ha000, m.got[4]);
    chk("rx words", 32'h44443333, rxw[31:0]);
    wr(ADDR_RSP_CTRL, {28'h0, RSP_DWORD}, 1'b0);
    wr(ADDR_RSP_VAL, 32'hcafe0123, 1'b0);
    rd(ADDR_STATUS, 32'h1, 32'h0);
    frame(6, 6);
    chk("rsp id", {4'h2, 1'b0, pn}, m.got[0]);
    chk("rsp hi", 32'hcafe, m.got[2]);
    chk("rsp lo", 32'h0123, m.got[3]);
    f[0] = m.mk(JOB_RSVD, pn);
    frame(6, 6);
    chk("err id", {4'h7, 1'b0, pn}, m.got[0]);
    chk("err num", 32'h006a, m.got[2]);
    chk("err lo", 32'h0, m.got[3]);
    rd(ADDR_REQ_VAL, 32'hffffffff, 32'h00005678);
    f[0] = {JOB_DWORD, 1'b1, pn};
    frame(6, 6);
    chk("rsvd id", {4'h7, 1'b0, pn}, m.got[0]);
    $display("test parameter channel done");
    wr(ADDR_TSEL, 32'h3e7, 1'b0);
    wr(ADDR_SRC_BASE + 12'hc, 32'h5, 1'b0);
    wr(ADDR_EXT, 32'h1, 1'b0);
    wr(ADDR_SRC_BASE, 32'h3, 1'b1);
    wr(ADDR_SRC_BASE + 12'h8, 32'h7, 1'b0);
    wr(ADDR_EXT, 32'h3e7, 1'b0);
    wr(ADDR_SRC_BASE, 32'h3, 1'b0);
    wr(ADDR_SRC_BASE, 32'h10, 1'b1);
    rd(ADDR_STATUS, 32'h0000000e, 32'h6);
    f[0] = 16'h5555;
    f[1] = 16'h6666;
    frame(2, 17);
    chk("free word0", 32'ha003, m.got[0]);
    chk("free word2", 32'ha007, m.got[2]);
    chk("free word3", 32'ha005, m.got[3]);
    $display("test free mapping done");
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    rd(ADDR_SRC_BASE + 12'h8, 32'hffffffff, 32'h2);
    rd(ADDR_TSEL, 32'hffffffff, 32'h1);
    $display("test mid-run reset done");
    finish_test();
  end
endmodule // telegram_channel_tb_top
